/* File: logic/operand_field_decoder.sv */
`timescale 1ns/1ps
`include "operand_decoder_cfg.svh"

module operand_field_decoder
    import operand_decoder_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // from instruction fetch
    input wire logic fetch_valid,
    input wire operand_decoder_pkg::fetch_s fetch,
    output logic fetch_ready,
    // working register window base
    input wire logic base_load,
    input wire logic [7:0] base_value,
    // to execution
    output logic dec_valid,
    output operand_decoder_pkg::decoded_s dec
);
    import operand_decoder_pkg::*;

    // ************************************************************
    // register base pointer
    // ************************************************************
    logic [7:0] register_base_pointer;
    logic [7:0] next_register_base_pointer;

    always_comb begin
        next_register_base_pointer = register_base_pointer;
        if (base_load) begin
            next_register_base_pointer = base_value;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            register_base_pointer <= `RBP_RESET;
        end else begin
            register_base_pointer <= next_register_base_pointer;
        end
    end

    // ************************************************************
    // field resolvers
    // ************************************************************
    logic [11:0] addr1;
    logic [11:0] addr2;
    logic [11:0] addr3;
    logic esc1;
    logic esc2;
    logic esc3;

    reg_field_resolver res1 (
        .field(fetch.byte1),
        .base_pointer(register_base_pointer),
        .addr(addr1),
        .escaped(esc1)
    );

    reg_field_resolver res2 (
        .field(fetch.byte2),
        .base_pointer(register_base_pointer),
        .addr(addr2),
        .escaped(esc2)
    );

    reg_field_resolver res3 (
        .field(fetch.byte3),
        .base_pointer(register_base_pointer),
        .addr(addr3),
        .escaped(esc3)
    );

    // ************************************************************
    // decode
    // ************************************************************
    decoded_s next_dec;
    logic next_dec_valid;
    logic [15:0] next_pc;
    logic [15:0] rel_offset;
    logic [11:0] index_ext;

    // the decoder never stalls fetch: one instruction per cycle
    assign fetch_ready = 1'b1;

    always_comb begin
        next_dec = '0;
        next_dec.form = form_none;
        next_dec_valid = fetch_valid;
        next_pc = fetch.pc + `JR_LEN;
        rel_offset = {{8{fetch.byte1[7]}}, fetch.byte1};
        index_ext = {{4{fetch.byte3[7]}}, fetch.byte3};
        case (fetch.opcode)
            `OPC_ADD_R_R: begin
                // source byte first, destination second
                next_dec.form = form_add_rr;
                next_dec.src_addr = addr1;
                next_dec.dst_addr = addr2;
                next_dec.writes_dst = 1'b1;
            end
            `OPC_ADD_R_IM: begin
                next_dec.form = form_add_im;
                next_dec.dst_addr = addr1;
                next_dec.src_is_imm = 1'b1;
                next_dec.imm = fetch.byte2;
                next_dec.writes_dst = 1'b1;
            end
            `OPC_JR: begin
                next_dec.form = form_rel;
                next_dec.target = next_pc + rel_offset;
            end
            `OPC_JP_DA: begin
                next_dec.form = form_direct;
                next_dec.target = {fetch.byte1, fetch.byte2};
            end
            `OPC_TRAP: begin
                next_dec.form = form_trap;
                next_dec.vector = fetch.byte1;
            end
            `OPC_ADDX: begin
                // two 12-bit addresses packed into three bytes
                next_dec.form = form_ext;
                next_dec.src_addr = {fetch.byte1, fetch.byte2[7:4]};
                next_dec.dst_addr = {fetch.byte2[3:0], fetch.byte3};
                next_dec.writes_dst = 1'b1;
            end
            `OPC_BIT: begin
                next_dec.form = form_bit;
                next_dec.polarity = fetch.byte1[`BIT_POL_POS];
                next_dec.bit_num =
                    fetch.byte1[`BIT_NUM_HI:`BIT_NUM_LO];
                next_dec.dst_addr = addr2;
                next_dec.writes_dst = 1'b1;
            end
            `OPC_LD_X: begin
                next_dec.form = form_index;
                next_dec.src_addr = addr2 + index_ext;
                next_dec.dst_addr = addr1;
                next_dec.writes_dst = 1'b1;
            end
            `OPC_INCW: begin
                next_dec.form = form_pair;
                next_dec.dst_addr = addr1;
                next_dec.illegal = fetch.byte1[0];
                next_dec.writes_dst = !fetch.byte1[0];
            end
            `OPC_INCW_RR: begin
                // odd pair index or missing escape is refused, not rounded
                next_dec.form = form_wpair;
                next_dec.dst_addr = addr1;
                next_dec.illegal = fetch.byte1[0] || !esc1;
                next_dec.writes_dst = !next_dec.illegal;
            end
            default: begin
                next_dec.form = form_none;
                next_dec.illegal = 1'b1;
            end
        endcase
        if (!fetch_valid) begin
            next_dec = '0;
            next_dec.form = form_none;
        end
    end

    // byte2 and byte3 escapes seen only for trace; not separate outputs
    logic unused_esc;
    assign unused_esc = esc2 ^ esc3 ^ addr3[0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dec <= '0;
            dec_valid <= 1'b0;
        end else begin
            dec <= next_dec;
            dec_valid <= next_dec_valid;
        end
    end
endmodule

/* File: pkg/operand_decoder_cfg.svh */
`ifndef OPERAND_DECODER_CFG_SVH
`define OPERAND_DECODER_CFG_SVH

// escape pattern in the upper nibble of an 8-bit register field
`define ESC_NIBBLE 4'he
// working registers sit in a 16-byte window at the base pointer
`define WREG_WINDOW_BITS 4
// opcode of the two-register add, source byte before destination
`define OPC_ADD_R_R 8'h04
// add with register destination, immediate source
`define OPC_ADD_R_IM 8'h06
// jump relative
`define OPC_JR 8'h8b
// direct jump
`define OPC_JP_DA 8'h8d
// software trap
`define OPC_TRAP 8'hf2
// add with extended addressing, source first
`define OPC_ADDX 8'h08
// bit set/clear with polarity
`define OPC_BIT 8'he2
// load with index
`define OPC_LD_X 8'hc7
// increment word on register pair
`define OPC_INCW 8'ha0
// increment word on working pair, escape form expected
`define OPC_INCW_RR 8'ha1
// bit field positions in a bit operand byte
`define BIT_POL_POS 7
`define BIT_NUM_HI 3
`define BIT_NUM_LO 1
// bytes of instruction length for the relative branch
`define JR_LEN 16'h0002
// register base pointer after reset
`define RBP_RESET 8'he0

`endif

/* File: pkg/operand_decoder_pkg.sv */
package operand_decoder_pkg;

    typedef enum logic [3:0] {
        form_none,
        form_add_rr,
        form_add_im,
        form_rel,
        form_direct,
        form_trap,
        form_ext,
        form_bit,
        form_index,
        form_pair,
        form_wpair
    } form_e;

    // instruction bytes as handed over by fetch
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] byte3;
    } fetch_s;

    // resolved operands
    typedef struct packed {
        form_e form;
        logic [11:0] dst_addr;
        logic [11:0] src_addr;
        logic src_is_imm;
        logic [7:0] imm;
        logic [15:0] target;
        logic [2:0] bit_num;
        logic polarity;
        logic [7:0] vector;
        logic writes_dst;
        logic illegal;
    } decoded_s;

endpackage

/* File: logic/reg_field_resolver.sv */
`timescale 1ns/1ps
`include "operand_decoder_cfg.svh"

// turns one 8-bit register field into a full register address
module reg_field_resolver
    import operand_decoder_pkg::*;
(
    // field and pointer
    input wire logic [7:0] field,
    input wire logic [7:0] base_pointer,
    // result
    output logic [11:0] addr,
    output logic escaped
);
    import operand_decoder_pkg::*;

    always_comb begin
        escaped = (field[7:4] == `ESC_NIBBLE);
        if (escaped) begin
            // working register: lower nibble within the pointer's window
            addr = {4'h0, base_pointer[7:`WREG_WINDOW_BITS],
                    field[`WREG_WINDOW_BITS-1:0]};
        end else begin
            addr = {4'h0, field};
        end
    end
endmodule

/* File: test/operand_field_decoder_props.sv */
`timescale 1ns/1ps
`include "operand_decoder_cfg.svh"
module operand_field_decoder_props
    import operand_decoder_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fetch side
    input wire logic fetch_valid,
    input wire operand_decoder_pkg::fetch_s fetch,
    input wire logic fetch_ready,
    input wire logic base_load,
    input wire logic [7:0] base_value,
    // decoded side
    input wire logic dec_valid,
    input wire operand_decoder_pkg::decoded_s dec
);
    import operand_decoder_pkg::*;
    fetch_s f;
    logic [7:0] op;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    assign op = fetch_valid ? fetch.opcode : 8'h00;
    // keep the taken bytes so checks read them one cycle later
    always_ff @(posedge core_clk) begin
        f <= fetch;
    end
    AST_ADD: assert property (
        op == `OPC_ADD_R_R && fetch.byte1[7:4] != `ESC_NIBBLE &&
        fetch.byte2[7:4] != `ESC_NIBBLE |=> dec_valid && dec.writes_dst &&
        dec.src_addr == {4'h0, f.byte1} && dec.dst_addr == {4'h0, f.byte2})
        else $error("add operands wrong");
    AST_ESCAPE: assert property (
        op == `OPC_ADD_R_R && fetch.byte1[7:4] == `ESC_NIBBLE |=>
        dec.src_addr[3:0] == f.byte1[3:0] && dec.src_addr[11:8] == 4'h0)
        else $error("escaped register wrong");
    AST_BIT: assert property (
        op == `OPC_BIT |=> dec.bit_num == f.byte1[3:1] &&
        dec.polarity == f.byte1[7]) else $error("bit fields wrong");
    AST_DIRECT: assert property (
        op == `OPC_JP_DA |=> dec.target == {f.byte1, f.byte2})
        else $error("direct target wrong");
    AST_EXT: assert property (
        op == `OPC_ADDX |=> dec.src_addr == {f.byte1, f.byte2[7:4]} &&
        dec.dst_addr == {f.byte2[3:0], f.byte3})
        else $error("extended operands wrong");
    AST_PAIR: assert property (
        op == `OPC_INCW && fetch.byte1[0] |=> dec.illegal && !dec.writes_dst)
        else $error("odd pair accepted");
    AST_REL: assert property (
        op == `OPC_JR |=> dec.target ==
        f.pc + `JR_LEN + {{8{f.byte1[7]}}, f.byte1})
        else $error("relative target wrong");
    AST_TRAP: assert property (
        op == `OPC_TRAP |=> dec.vector == f.byte1)
        else $error("trap vector wrong");
endmodule
bind operand_field_decoder operand_field_decoder_props u_props(
    .core_clk(core_clk), .rst(rst), .fetch_valid(fetch_valid),
    .fetch(fetch), .fetch_ready(fetch_ready), .base_load(base_load),
    .base_value(base_value), .dec_valid(dec_valid), .dec(dec));

/* File: test/fetch_source.sv */
`timescale 1ns/1ps
// fetch stand-in: bytes are scrambled while idle, never left stale
module fetch_source
    import operand_decoder_pkg::*;
(
    // clock
    input wire logic core_clk,
    // to the decoder
    output logic fetch_valid,
    output operand_decoder_pkg::fetch_s fetch
);
    import operand_decoder_pkg::*;
    initial begin
        fetch_valid = 1'b0;
        fetch = '0;
    end
    // called at a falling edge; holds across one rising edge
    task automatic send(input logic [7:0] op, b1, b2, b3,
        input logic [15:0] pc = 16'h1000);
        fetch_valid = 1'b1;
        fetch = {pc, op, b1, b2, b3};
        @(negedge core_clk);
    endtask
    // lets one rising edge pass so the next send never re-drives this step
    task automatic idle();
        fetch_valid = 1'b0;
        fetch = ~fetch;
        @(negedge core_clk);
    endtask
endmodule

/* File: test/test_operand_field_decoder.sv */
`timescale 1ns/1ps
module test_operand_field_decoder;
    import operand_decoder_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic base_load = 1'b0;
    logic [7:0] base_value = 8'h00;
    logic fetch_valid;
    logic fetch_ready;
    logic dec_valid;
    fetch_s fetch;
    decoded_s dec;
    int err_total = 0;
    int check_count = 0;
    always #20 core_clk = ~core_clk;
    fetch_source u_src(.core_clk(core_clk), .fetch_valid(fetch_valid),
        .fetch(fetch));
    operand_field_decoder u_dut(.core_clk(core_clk), .rst(rst),
        .fetch_valid(fetch_valid), .fetch(fetch),
        .fetch_ready(fetch_ready), .base_load(base_load),
        .base_value(base_value), .dec_valid(dec_valid), .dec(dec));
    task automatic chk(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // back to back adds, then a moved window base
    task automatic add_order();
        u_src.send(8'h04, 8'h08, 8'h43, 8'h00);
        chk(dec_valid, 1);
        chk(dec.src_addr, 12'h008);
        chk(dec.dst_addr, 12'h043);
        chk(dec.writes_dst, 1);
        u_src.send(8'h04, 8'he8, 8'h43, 8'h00);
        chk(dec.src_addr, 12'h0e8);
        chk(fetch_ready, 1'b1);
        u_src.idle();
        chk(dec_valid, 1'b0);
        base_load = 1'b1;
        base_value = 8'h30;
        @(negedge core_clk);
        base_load = 1'b0;
        u_src.send(8'h04, 8'he8, 8'hff, 8'h00);
        chk(dec.src_addr, 12'h038);
        chk(dec.dst_addr, 12'h0ff);
        u_src.idle();
    endtask
    // offsets at both ends of the signed range, wrap included
    task automatic branches();
        u_src.send(8'h8b, 8'h80, 8'h00, 8'h00);
        chk(dec.target, 16'h0f82);
        u_src.send(8'h8b, 8'h7f, 8'h00, 8'h00, 16'hfff0);
        chk(dec.target, 16'h0071);
        u_src.send(8'h8d, 8'hff, 8'hff, 8'h00);
        chk(dec.target, 16'hffff);
        u_src.send(8'hf2, 8'hff, 8'h00, 8'h00);
        chk(dec.vector, 8'hff);
        u_src.idle();
    endtask
    task automatic fields();
        u_src.send(8'h08, 8'hab, 8'hcd, 8'hef);
        chk(dec.src_addr, 12'habc);
        chk(dec.dst_addr, 12'hdef);
        u_src.send(8'he2, 8'h8e, 8'h55, 8'h00);
        chk(dec.bit_num, 3'h7);
        chk(dec.polarity, 1'b1);
        u_src.send(8'he2, 8'h00, 8'h55, 8'h00);
        chk(dec.bit_num, 3'h0);
        chk(dec.polarity, 1'b0);
        u_src.send(8'h06, 8'h43, 8'hff, 8'h00);
        chk(dec.imm, 8'hff);
        chk(dec.src_is_imm, 1'b1);
        u_src.send(8'hc7, 8'h43, 8'h10, 8'hff);
        chk(dec.src_addr, 12'h00f);
        u_src.idle();
    endtask
    // pairs: top even, odd, escaped even, escaped odd, unescaped
    task automatic pairs();
        logic [15:0] tab [5] = '{16'ha0fe, 16'ha041, 16'ha1ee, 16'ha1e3,
            16'ha108};
        logic bad [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        foreach (tab[i]) begin
            u_src.send(tab[i][15:8], tab[i][7:0], 8'h00, 8'h00);
            chk(dec.illegal, bad[i]);
        end
        u_src.send(8'hff, 8'h00, 8'h00, 8'h00);
        chk(dec.form, form_none);
        chk(dec.illegal, 1'b1);
        u_src.idle();
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        add_order();
        branches();
        fields();
        pairs();
        summarize();
    end
endmodule
